// ### rtl/mrs_defines.svh
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH

`define MRS_ADDR_CMD 8'h00
`define MRS_ADDR_MEM 8'h04
`define MRS_ADDR_WREG 8'h08
`define MRS_ADDR_STATUS 8'h0c
`define MRS_ADDR_PC 8'h10
`define MRS_ADDR_STACK 8'h14

`define MRS_CMD_BIT_LSB 8
`define MRS_CMD_IMM_LSB 16

`define MRS_ST_C 0
`define MRS_ST_Z 1
`define MRS_ST_OV 2
`define MRS_ST_AC 3
`define MRS_ST_MIE 4
`define MRS_ST_BUSY 5
`define MRS_ST_SKIP 6
`define MRS_ST_SVC 7
`define MRS_ST_MEMWR 8

`define MRS_RST_BYTE 8'h00
`define MRS_RST_PC 16'h0000
`define MRS_IRQ_VEC 16'h0004
`define MRS_RESP_OKAY 2'b00
`define MRS_RESP_SLVERR 2'b10

`define MRS_OP_NOP 5'h00
`define MRS_OP_RET_IMM 5'h01
`define MRS_OP_IRET 5'h02
`define MRS_OP_RL 5'h03
`define MRS_OP_RLA 5'h04
`define MRS_OP_RLC 5'h05
`define MRS_OP_ROTATE_LEFT_CARRY_TO_WREG 5'h06
`define MRS_OP_RR 5'h07
`define MRS_OP_RRA 5'h08
`define MRS_OP_RRC 5'h09
`define MRS_OP_ROTATE_RIGHT_CARRY_TO_WREG 5'h0a
`define MRS_OP_SBC 5'h0b
`define MRS_OP_MINUS_WITH_BORROW_TO_MEMORY 5'h0c
`define MRS_OP_SUB 5'h0d
`define MRS_OP_MINUS_TO_MEMORY 5'h0e
`define MRS_OP_SUBI 5'h0f
`define MRS_OP_SDZ 5'h10
`define MRS_OP_DECREMENT_TO_WREG_SKIP_IF_ZERO 5'h11
`define MRS_OP_SIZ 5'h12
`define MRS_OP_INCREMENT_TO_WREG_SKIP_IF_ZERO 5'h13
`define MRS_OP_SET 5'h14
`define MRS_OP_SETB 5'h15
`define MRS_OP_SNZ 5'h16
`define MRS_OP_SWAP 5'h17

`endif

// ### rtl/mrs_pkg.sv
package mrs_pkg;
	typedef enum logic [2:0] {
		MRS_IDLE = 3'b001,
		MRS_EXEC = 3'b010,
		MRS_DUMMY = 3'b100
	} mrs_state_t;
	typedef logic [4:0] mrs_op_t;
endpackage : mrs_pkg

// ### rtl/mrs_datapath.sv
// What this block does
// - Immediate return: pc from stack, wreg gets immediate
// - Interrupt return: pc from stack unless a request is pending, enable set
// - Pending interrupt serviced right after interrupt return
// - Rotate left in memory, flags untouched
// - Rotate right in memory, flags untouched
// - Left through carry: bit7 to carry
// - Right through carry: bit0 to carry
// - Rotate to wreg leaves memory unchanged
// - Borrow subtract, wreg or memory, four flags
// - Plain subtract of memory or immediate
// - Carry is inverted borrow on subtract
// - Step memory by one, skip on zero
// - Step into wreg only, skip on zero
// - Skip instructions take two cycles
// - Byte set writes all ones
// - Bit set forces one bit only
// - Bit test skips when bit set
// - Nibble exchange written back to memory
`timescale 1ns/1ps
`default_nettype none
`include "mrs_defines.svh"
module mrs_datapath
	import mrs_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq_pending,
	output logic master_interrupt_enable,
	output logic irq_service
);

	mrs_state_t state_q;
	mrs_op_t op_q;
	logic [2:0] bit_q;
	logic [7:0] imm_q, mem_q, wreg_q;
	logic c_q, z_q, ov_q, ac_q, mie_q, skip_q, svc_q, memwr_q;
	logic [15:0] pc_q, stack_q;

	logic aw_ok_q, w_ok_q, bvalid_q, rvalid_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;

	logic wr_fire, idle, start, wr_ok, ex_now;
	logic [31:0] rd_mux;
	logic rd_err;

	assign idle = state_q == MRS_IDLE;
	assign ex_now = state_q == MRS_EXEC;
	assign wr_fire = aw_ok_q && w_ok_q && !bvalid_q;
	assign wr_ok = wr_fire && idle;
	assign start = wr_ok && awaddr_q == `MRS_ADDR_CMD && wstrb_q[0];

	// AXI4-Lite write channels taken in either order
	assign s_axi_awready = !aw_ok_q && !bvalid_q;
	assign s_axi_wready = !w_ok_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign master_interrupt_enable = mie_q;
	assign irq_service = svc_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_q <= 1'b0;
			awaddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_ok_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_ok_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_ok_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_ok_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_ok_q <= 1'b0;
		end
	end

	// Writes while busy or unmapped are dropped with SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `MRS_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			if (!idle) begin
				bresp_q <= `MRS_RESP_SLVERR;
			end else if (awaddr_q == `MRS_ADDR_CMD || awaddr_q == `MRS_ADDR_MEM ||
				awaddr_q == `MRS_ADDR_WREG || awaddr_q == `MRS_ADDR_STATUS ||
				awaddr_q == `MRS_ADDR_PC || awaddr_q == `MRS_ADDR_STACK) begin
				bresp_q <= `MRS_RESP_OKAY;
			end else begin
				bresp_q <= `MRS_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_comb begin
		rd_mux = '0;
		rd_err = 1'b0;
		if (s_axi_araddr == `MRS_ADDR_CMD) begin
			rd_mux = {8'h00, imm_q, 5'h00, bit_q, 3'h0, op_q};
		end else if (s_axi_araddr == `MRS_ADDR_MEM) begin
			rd_mux = {24'h000000, mem_q};
		end else if (s_axi_araddr == `MRS_ADDR_WREG) begin
			rd_mux = {24'h000000, wreg_q};
		end else if (s_axi_araddr == `MRS_ADDR_STATUS) begin
			rd_mux[`MRS_ST_C] = c_q;
			rd_mux[`MRS_ST_Z] = z_q;
			rd_mux[`MRS_ST_OV] = ov_q;
			rd_mux[`MRS_ST_AC] = ac_q;
			rd_mux[`MRS_ST_MIE] = mie_q;
			rd_mux[`MRS_ST_BUSY] = !idle;
			rd_mux[`MRS_ST_SKIP] = skip_q;
			rd_mux[`MRS_ST_SVC] = svc_q;
			rd_mux[`MRS_ST_MEMWR] = memwr_q;
		end else if (s_axi_araddr == `MRS_ADDR_PC) begin
			rd_mux = {16'h0000, pc_q};
		end else if (s_axi_araddr == `MRS_ADDR_STACK) begin
			rd_mux = {16'h0000, stack_q};
		end else begin
			rd_err = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `MRS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_err ? `MRS_RESP_SLVERR : `MRS_RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Execution results for the latched operation
	logic [7:0] sub_b, ex_val, inc_v, dec_v;
	logic [8:0] diff9;
	logic [4:0] low5;
	logic bin, ex_mem_we, ex_wreg_we, ex_c_we, ex_c, ex_arith, ex_skip_op, ex_skip;

	always_comb begin
		sub_b = (op_q == `MRS_OP_SUBI) ? imm_q : mem_q;
		bin = (op_q == `MRS_OP_SBC || op_q == `MRS_OP_MINUS_WITH_BORROW_TO_MEMORY) ? !c_q : 1'b0;
		diff9 = {1'b0, wreg_q} - {1'b0, sub_b} - {8'h00, bin};
		low5 = {1'b0, wreg_q[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, bin};
		inc_v = mem_q + 8'h01;
		dec_v = mem_q - 8'h01;
		ex_val = mem_q;
		ex_mem_we = 1'b0;
		ex_wreg_we = 1'b0;
		ex_c_we = 1'b0;
		ex_c = c_q;
		ex_arith = 1'b0;
		ex_skip_op = 1'b0;
		ex_skip = 1'b0;
		case (op_q)
			`MRS_OP_RET_IMM: begin
				ex_val = imm_q;
				ex_wreg_we = 1'b1;
			end
			`MRS_OP_RL, `MRS_OP_RLA: begin
				ex_val = {mem_q[6:0], mem_q[7]};
				ex_mem_we = op_q == `MRS_OP_RL;
				ex_wreg_we = op_q == `MRS_OP_RLA;
			end
			`MRS_OP_RLC, `MRS_OP_ROTATE_LEFT_CARRY_TO_WREG: begin
				ex_val = {mem_q[6:0], c_q};
				ex_c_we = 1'b1;
				ex_c = mem_q[7];
				ex_mem_we = op_q == `MRS_OP_RLC;
				ex_wreg_we = op_q == `MRS_OP_ROTATE_LEFT_CARRY_TO_WREG;
			end
			`MRS_OP_RR, `MRS_OP_RRA: begin
				ex_val = {mem_q[0], mem_q[7:1]};
				ex_mem_we = op_q == `MRS_OP_RR;
				ex_wreg_we = op_q == `MRS_OP_RRA;
			end
			`MRS_OP_RRC, `MRS_OP_ROTATE_RIGHT_CARRY_TO_WREG: begin
				ex_val = {c_q, mem_q[7:1]};
				ex_c_we = 1'b1;
				ex_c = mem_q[0];
				ex_mem_we = op_q == `MRS_OP_RRC;
				ex_wreg_we = op_q == `MRS_OP_ROTATE_RIGHT_CARRY_TO_WREG;
			end
			`MRS_OP_SBC, `MRS_OP_MINUS_WITH_BORROW_TO_MEMORY, `MRS_OP_SUB, `MRS_OP_MINUS_TO_MEMORY, `MRS_OP_SUBI: begin
				ex_val = diff9[7:0];
				ex_c_we = 1'b1;
				ex_c = !diff9[8];
				ex_arith = 1'b1;
				ex_mem_we = op_q == `MRS_OP_MINUS_WITH_BORROW_TO_MEMORY || op_q == `MRS_OP_MINUS_TO_MEMORY;
				ex_wreg_we = !ex_mem_we;
			end
			`MRS_OP_SDZ, `MRS_OP_DECREMENT_TO_WREG_SKIP_IF_ZERO, `MRS_OP_SIZ, `MRS_OP_INCREMENT_TO_WREG_SKIP_IF_ZERO: begin
				ex_val = (op_q == `MRS_OP_SDZ || op_q == `MRS_OP_DECREMENT_TO_WREG_SKIP_IF_ZERO) ? dec_v : inc_v;
				ex_mem_we = op_q == `MRS_OP_SDZ || op_q == `MRS_OP_SIZ;
				ex_wreg_we = !ex_mem_we;
				ex_skip_op = 1'b1;
				ex_skip = ex_val == 8'h00;
			end
			`MRS_OP_SET: begin
				ex_val = 8'hff;
				ex_mem_we = 1'b1;
			end
			`MRS_OP_SETB: begin
				ex_val = mem_q | (8'h01 << bit_q);
				ex_mem_we = 1'b1;
			end
			`MRS_OP_SNZ: begin
				ex_skip_op = 1'b1;
				ex_skip = mem_q[bit_q];
			end
			`MRS_OP_SWAP: begin
				ex_val = {mem_q[3:0], mem_q[7:4]};
				ex_mem_we = 1'b1;
			end
			default: begin
				ex_val = mem_q;
			end
		endcase
	end

	// skip class adds a dummy cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= MRS_IDLE;
		end else begin
			case (state_q)
				MRS_IDLE: if (start) state_q <= MRS_EXEC;
				MRS_EXEC: state_q <= ex_skip_op ? MRS_DUMMY : MRS_IDLE;
				MRS_DUMMY: state_q <= MRS_IDLE;
				default: state_q <= MRS_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_q <= `MRS_OP_NOP;
			bit_q <= 3'h0;
			imm_q <= `MRS_RST_BYTE;
		end else if (wr_ok && awaddr_q == `MRS_ADDR_CMD) begin
			if (wstrb_q[0]) op_q <= wdata_q[4:0];
			if (wstrb_q[1]) bit_q <= wdata_q[`MRS_CMD_BIT_LSB +: 3];
			if (wstrb_q[2]) imm_q <= wdata_q[`MRS_CMD_IMM_LSB +: 8];
		end
	end

	// Memory operand and working register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_q <= `MRS_RST_BYTE;
			wreg_q <= `MRS_RST_BYTE;
		end else if (ex_now) begin
			if (ex_mem_we) mem_q <= ex_val;
			if (ex_wreg_we) wreg_q <= ex_val;
		end else if (wr_ok && wstrb_q[0]) begin
			if (awaddr_q == `MRS_ADDR_MEM) mem_q <= wdata_q[7:0];
			if (awaddr_q == `MRS_ADDR_WREG) wreg_q <= wdata_q[7:0];
		end
	end

	// Flags and interrupt enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c_q <= 1'b0;
			z_q <= 1'b0;
			ov_q <= 1'b0;
			ac_q <= 1'b0;
			mie_q <= 1'b0;
		end else if (ex_now) begin
			if (ex_c_we) c_q <= ex_c;
			if (ex_arith) begin
				z_q <= ex_val == 8'h00;
				ov_q <= (wreg_q[7] != sub_b[7]) && (ex_val[7] != wreg_q[7]);
				ac_q <= !low5[4];
			end
			if (op_q == `MRS_OP_IRET) mie_q <= 1'b1;
		end else if (wr_ok && awaddr_q == `MRS_ADDR_STATUS && wstrb_q[0]) begin
			c_q <= wdata_q[`MRS_ST_C];
			z_q <= wdata_q[`MRS_ST_Z];
			ov_q <= wdata_q[`MRS_ST_OV];
			ac_q <= wdata_q[`MRS_ST_AC];
			mie_q <= wdata_q[`MRS_ST_MIE];
		end
	end

	// Program counter, stack top, outcome status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_q <= `MRS_RST_PC;
			stack_q <= `MRS_RST_PC;
			skip_q <= 1'b0;
			svc_q <= 1'b0;
			memwr_q <= 1'b0;
		end else if (ex_now) begin
			skip_q <= ex_skip;
			memwr_q <= ex_mem_we;
			svc_q <= 1'b0;
			if (op_q == `MRS_OP_RET_IMM) begin
				pc_q <= stack_q;
			end else if (op_q == `MRS_OP_IRET) begin
				// pending request vectored before main code
				pc_q <= irq_pending ? `MRS_IRQ_VEC : stack_q;
				svc_q <= irq_pending;
			end else if (ex_skip) begin
				pc_q <= pc_q + 16'h0002;
			end else begin
				pc_q <= pc_q + 16'h0001;
			end
		end else if (wr_ok && awaddr_q == `MRS_ADDR_PC) begin
			if (wstrb_q[0]) pc_q[7:0] <= wdata_q[7:0];
			if (wstrb_q[1]) pc_q[15:8] <= wdata_q[15:8];
		end else if (wr_ok && awaddr_q == `MRS_ADDR_STACK) begin
			if (wstrb_q[0]) stack_q[7:0] <= wdata_q[7:0];
			if (wstrb_q[1]) stack_q[15:8] <= wdata_q[15:8];
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_ret_imm;
		ex_now && op_q == `MRS_OP_RET_IMM |=> wreg_q == $past(imm_q) &&
			pc_q == $past(stack_q) && $stable({c_q, z_q, ov_q, ac_q});
	endproperty
	a_ret_imm: assert property (p_ret_imm) else $error("immediate return wrong");

	property p_iret;
		ex_now && op_q == `MRS_OP_IRET && !irq_pending |=> mie_q && pc_q == $past(stack_q) &&
			$stable({c_q, z_q, ov_q, ac_q});
	endproperty
	a_iret: assert property (p_iret) else $error("interrupt return wrong");

	property p_iret_pend;
		ex_now && op_q == `MRS_OP_IRET && irq_pending |=> pc_q == `MRS_IRQ_VEC && svc_q;
	endproperty
	a_iret_pend: assert property (p_iret_pend) else $error("pending request lost");

	property p_rl;
		ex_now && op_q == `MRS_OP_RL |=> mem_q == {$past(mem_q[6:0]), $past(mem_q[7])} &&
			$stable(c_q);
	endproperty
	a_rl: assert property (p_rl) else $error("rotate left wrong");

	property p_rr;
		ex_now && op_q == `MRS_OP_RR |=> mem_q == {$past(mem_q[0]), $past(mem_q[7:1])} &&
			$stable(c_q);
	endproperty
	a_rr: assert property (p_rr) else $error("rotate right wrong");

	property p_rlc;
		ex_now && op_q == `MRS_OP_RLC |=> c_q == $past(mem_q[7]) &&
			mem_q[0] == $past(c_q) && $stable(z_q);
	endproperty
	a_rlc: assert property (p_rlc) else $error("carry rotate left wrong");

	property p_rrc;
		ex_now && op_q == `MRS_OP_RRC |=> c_q == $past(mem_q[0]) && mem_q[7] == $past(c_q);
	endproperty
	a_rrc: assert property (p_rrc) else $error("carry rotate right wrong");

	property p_rotate_left_carry_to_wreg;
		ex_now && op_q == `MRS_OP_ROTATE_LEFT_CARRY_TO_WREG |=> $stable(mem_q) &&
			wreg_q == {$past(mem_q[6:0]), $past(c_q)};
	endproperty
	a_rotate_left_carry_to_wreg: assert property (p_rotate_left_carry_to_wreg) else $error("wreg rotate touched memory");

	property p_sbc;
		ex_now && op_q == `MRS_OP_SBC |=>
			wreg_q == 8'($past(wreg_q) - $past(mem_q) - {7'h00, !$past(c_q)});
	endproperty
	a_sbc: assert property (p_sbc) else $error("borrow subtract wrong");

	property p_sub_c;
		ex_now && op_q == `MRS_OP_SUB |=> c_q == ($past(wreg_q) >= $past(mem_q)) &&
			z_q == ($past(wreg_q) == $past(mem_q));
	endproperty
	a_sub_c: assert property (p_sub_c) else $error("subtract carry wrong");

	property p_sdz;
		ex_now && op_q == `MRS_OP_SDZ && mem_q == 8'h01 |=> mem_q == 8'h00 && skip_q &&
			pc_q == 16'($past(pc_q) + 16'h0002);
	endproperty
	a_sdz: assert property (p_sdz) else $error("decrement skip wrong");

	property p_increment_to_wreg_skip_if_zero;
		ex_now && op_q == `MRS_OP_INCREMENT_TO_WREG_SKIP_IF_ZERO |=> $stable(mem_q) && skip_q == (wreg_q == 8'h00);
	endproperty
	a_increment_to_wreg_skip_if_zero: assert property (p_increment_to_wreg_skip_if_zero) else $error("wreg increment skip wrong");

	property p_two_cycle;
		ex_now && ex_skip_op |=> state_q == MRS_DUMMY ##1 state_q == MRS_IDLE;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("skip not two cycles");

	property p_snz;
		ex_now && op_q == `MRS_OP_SNZ |=> skip_q == $past(mem_q[bit_q]) && $stable(mem_q);
	endproperty
	a_snz: assert property (p_snz) else $error("bit test wrong");

	property p_swap;
		ex_now && op_q == `MRS_OP_SWAP |=> mem_q == {$past(mem_q[3:0]), $past(mem_q[7:4])};
	endproperty
	a_swap: assert property (p_swap) else $error("nibble exchange wrong");

	c_skip_taken: cover property (ex_now && ex_skip);
	c_iret_pend: cover property (ex_now && op_q == `MRS_OP_IRET && irq_pending);
	c_sub_borrow: cover property (ex_now && ex_arith && !ex_c);
	c_busy_write: cover property (wr_fire && !idle);

endmodule : mrs_datapath
`default_nettype wire

// ### sim/mrs_datapath_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mrs_defines.svh"
module mrs_datapath_tb;
	logic aclk, aresetn, irq_pending;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic master_interrupt_enable, irq_service;
	int fail_count, checks;

	mrs_datapath dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .irq_pending(irq_pending),
		.master_interrupt_enable(master_interrupt_enable), .irq_service(irq_service));

	always #10 aclk = ~aclk;

	task automatic finish_test();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic tmo();
		fail_count++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
		finish_test();
	endtask : tmo

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic a_p, w_p, ha, hw, hb;
		a_p = 1;
		w_p = 1;
		hb = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 50 && !hb; n++) begin
			@(negedge aclk);
			ha = a_p && s_axi_awready;
			hw = w_p && s_axi_wready;
			hb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ha) begin
				s_axi_awvalid <= 1'b0;
				a_p = 0;
			end
			if (hw) begin
				s_axi_wvalid <= 1'b0;
				w_p = 0;
			end
			if (hb)
				s_axi_bready <= 1'b0;
		end
		if (!hb)
			tmo();
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic a_p, ha, done;
		a_p = 1;
		done = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge aclk);
			ha = a_p && s_axi_arready;
			done = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ha) begin
				s_axi_arvalid <= 1'b0;
				a_p = 0;
			end
			if (done)
				s_axi_rready <= 1'b0;
		end
		if (!done)
			tmo();
	endtask : axi_rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk({30'h0, r}, {30'h0, `MRS_RESP_OKAY});
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, `MRS_RESP_OKAY});
	endtask : rdc

	// Loads operands, runs one op, compares every visible result
	task automatic ex(input logic [4:0] op, input logic [2:0] bi, input logic [7:0] imm,
			input logic [7:0] m, input logic [7:0] w, input logic [4:0] st);
		logic [8:0] r;
		logic [4:0] h;
		logic [7:0] b, em, ew;
		logic [3:0] f;
		logic sk, mw, bin, svc, mie;
		logic [15:0] pc;
		logic [31:0] d;
		logic [1:0] rs;
		em = m;
		ew = w;
		f = st[3:0];
		sk = 0;
		mw = 0;
		r = 9'h0;
		pc = 16'h0011;
		svc = (op == 5'h02) && irq_pending;
		mie = (op == 5'h02) ? 1'b1 : st[4];
		case (op)
			5'h01: begin
				pc = 16'h0123;
				ew = imm;
			end
			5'h02: pc = irq_pending ? `MRS_IRQ_VEC : 16'h0123;
			5'h03, 5'h04: r[7:0] = {m[6:0], m[7]};
			5'h05, 5'h06: begin
				r[7:0] = {m[6:0], f[0]};
				f[0] = m[7];
			end
			5'h07, 5'h08: r[7:0] = {m[0], m[7:1]};
			5'h09, 5'h0a: begin
				r[7:0] = {f[0], m[7:1]};
				f[0] = m[0];
			end
			5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f: begin
				b = (op == 5'h0f) ? imm : m;
				bin = (op < 5'h0d) && !f[0];
				r = {1'b0, w} - {1'b0, b} - {8'h0, bin};
				h = {1'b0, w[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
				f = {~h[4], (w[7] != b[7]) && (r[7] != w[7]), r[7:0] == 8'h0, ~r[8]};
			end
			5'h10, 5'h11: r[7:0] = m - 8'h01;
			5'h12, 5'h13: r[7:0] = m + 8'h01;
			5'h14: r[7:0] = 8'hff;
			5'h15: r[7:0] = m | (8'h01 << bi);
			5'h17: r[7:0] = {m[3:0], m[7:4]};
			default: ;
		endcase
		if (op inside {5'h04, 5'h06, 5'h08, 5'h0a, 5'h0b, 5'h0d, 5'h0f, 5'h11, 5'h13})
			ew = r[7:0];
		if (op inside {5'h03, 5'h05, 5'h07, 5'h09, 5'h0c, 5'h0e, 5'h10, 5'h12, 5'h14, 5'h15,
				5'h17}) begin
			em = r[7:0];
			mw = 1;
		end
		if (op inside {[5'h10:5'h13]})
			sk = (r[7:0] == 8'h0);
		if (op == 5'h16)
			sk = m[bi];
		if (sk)
			pc = 16'h0012;
		wr(`MRS_ADDR_MEM, {24'h0, m});
		wr(`MRS_ADDR_WREG, {24'h0, w});
		wr(`MRS_ADDR_STATUS, {27'h0, st});
		wr(`MRS_ADDR_PC, 32'h10);
		wr(`MRS_ADDR_STACK, 32'h123);
		wr(`MRS_ADDR_CMD, {8'h0, imm, 5'h0, bi, 3'h0, op});
		d = 32'h20;
		for (int n = 0; n < 20 && d[5]; n++)
			axi_rd(`MRS_ADDR_STATUS, d, rs);
		if (d[5])
			tmo();
		rdc(`MRS_ADDR_MEM, {24'h0, em});
		rdc(`MRS_ADDR_WREG, {24'h0, ew});
		rdc(`MRS_ADDR_STATUS, {23'h0, mw, svc, sk, 1'b0, mie, f});
		rdc(`MRS_ADDR_PC, {16'h0, pc});
		chk({31'h0, master_interrupt_enable}, {31'h0, mie});
		chk({31'h0, irq_service}, {31'h0, svc});
	endtask : ex

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 6; i++)
			rdc(8'(i * 4), 32'h0);
		chk({31'h0, master_interrupt_enable}, 32'h0);
		axi_rd(8'h20, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, `MRS_RESP_SLVERR});
		axi_wr(8'h24, 32'h5a, r);
		chk({30'h0, r}, {30'h0, `MRS_RESP_SLVERR});
		$display("test reset done");
	endtask : t_reset

	task automatic t_rot();
		for (int i = 3; i <= 10; i++) begin
			ex(5'(i), 3'h0, 8'h0, 8'h96, 8'h3c, 5'h0e);
			ex(5'(i), 3'h0, 8'h0, 8'h69, 8'h3c, 5'h01);
		end
		$display("test rotate done");
	endtask : t_rot

	task automatic t_sub();
		logic [7:0] wv[5] = '{8'h50, 8'h30, 8'h80, 8'h12, 8'h7f};
		logic [7:0] mv[5] = '{8'h30, 8'h50, 8'h01, 8'h12, 8'hff};
		for (int o = 11; o <= 15; o++)
			for (int k = 0; k < 5; k++)
				ex(5'(o), 3'h0, mv[k] ^ 8'h0f, mv[k], wv[k], {4'h0, k[0]});
		$display("test subtract done");
	endtask : t_sub

	task automatic t_skip();
		logic [7:0] mv[4] = '{8'h01, 8'h02, 8'hff, 8'h00};
		for (int o = 16; o <= 19; o++)
			for (int k = 0; k < 4; k++)
				ex(5'(o), 3'h0, 8'h0, mv[k], 8'h77, 5'h0a);
		for (int i = 0; i < 8; i++)
			ex(5'h16, 3'(i), 8'h0, 8'ha5, 8'h11, 5'h05);
		$display("test skip done");
	endtask : t_skip

	task automatic t_bits();
		ex(5'h14, 3'h0, 8'h0, 8'h12, 8'h34, 5'h0f);
		for (int i = 0; i < 8; i++)
			ex(5'h15, 3'(i), 8'h0, 8'h42, 8'h34, 5'h05);
		ex(5'h17, 3'h0, 8'h0, 8'h3c, 8'h34, 5'h0a);
		$display("test bits done");
	endtask : t_bits

	task automatic t_ret();
		ex(5'h01, 3'h0, 8'h5e, 8'h12, 8'h34, 5'h0f);
		ex(5'h02, 3'h0, 8'h0, 8'h12, 8'h34, 5'h05);
		irq_pending <= 1'b1;
		// Let the request settle before the expectation reads it
		@(posedge aclk);
		ex(5'h02, 3'h0, 8'h0, 8'h12, 8'h34, 5'h0a);
		irq_pending <= 1'b0;
		@(posedge aclk);
		ex(5'h00, 3'h0, 8'h0, 8'h12, 8'h34, 5'h10);
		$display("test return done");
	endtask : t_ret

	initial begin
		aclk = 0;
		aresetn = 0;
		irq_pending = 0;
		s_axi_awaddr = 8'h0;
		s_axi_awvalid = 0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 0;
		s_axi_bready = 0;
		s_axi_araddr = 8'h0;
		s_axi_arvalid = 0;
		s_axi_rready = 0;
		fail_count = 0;
		checks = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_rot();
		t_sub();
		t_skip();
		t_bits();
		t_ret();
		finish_test();
	end
endmodule : mrs_datapath_tb
`default_nettype wire
